// *** qtw_defines.svh ***
// Constants for the quad timer watchdog block
`ifndef QTW_DEFINES_SVH
`define QTW_DEFINES_SVH
// ----------------------------------------------------------------
// Widths and counts
// ----------------------------------------------------------------
`define QTW_NTIM        4
`define QTW_CNT_W       24
`define QTW_CNT_MAX     24'hFFFFFF
`define QTW_ADDR_W      7
`define QTW_STAT_W      8
// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define QTW_OFS_CTRL    4'h0
`define QTW_OFS_INIT    4'h4
`define QTW_OFS_COUNT   4'h8
`define QTW_OFS_KICK    4'hC
`define QTW_OFS_STATUS  7'h40
`define QTW_OFS_MASK    7'h44
// ----------------------------------------------------------------
// Control field positions and reset values
// ----------------------------------------------------------------
`define QTW_CTRL_W      5
`define QTW_CTRL_RUN    0
`define QTW_CTRL_DOWN   1
`define QTW_CTRL_TSEL   2
`define QTW_CTRL_WDEN   4
`define QTW_CTRL_RST    5'h00
`define QTW_INIT_RST    24'h000000
`define QTW_STAT_RST    8'h00
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define QTW_CLK_NS      10
`define QTW_TB0_NS      100
`define QTW_TB1_NS      10000
`define QTW_TB2_NS      100000
`define QTW_TB3_NS      1000000
`define QTW_DIV0        (`QTW_TB0_NS / `QTW_CLK_NS)
`define QTW_DIV1        (`QTW_TB1_NS / `QTW_TB0_NS)
`define QTW_DIV2        (`QTW_TB2_NS / `QTW_TB1_NS)
`define QTW_DIV3        (`QTW_TB3_NS / `QTW_TB2_NS)
`define QTW_WD_RST_CYC  16
`endif

// *** qtw_pkg.sv ***
// Types for the quad timer watchdog block
`default_nettype none
package qtw_pkg;
  // Bus slave states, Gray coded
  typedef enum logic [1:0] {
    QTW_BUS_IDLE = 2'h0,
    QTW_BUS_ACK  = 2'h1
  } qtw_bus_e;
  // Time base selection
  typedef enum logic [1:0] {
    QTW_TB_100NS = 2'h0,
    QTW_TB_10US  = 2'h1,
    QTW_TB_100US = 2'h2,
    QTW_TB_1MS   = 2'h3
  } qtw_tb_e;
endpackage : qtw_pkg
`default_nettype wire

// *** qtw_tick_gen.sv ***
// Cascaded time base tick generator
`timescale 1ns/1ps
`default_nettype none
module qtw_tick_gen #(
  parameter int D0 = 10,
  parameter int D1 = 100,
  parameter int D2 = 10,
  parameter int D3 = 10
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic       ce,
  // Single-cycle ticks: 100 ns, 10 us, 100 us, 1 ms
  output logic      [3:0] tick
);
  localparam logic [63:0] DIVV = {16'(D3), 16'(D2), 16'(D1), 16'(D0)};
  logic [3:0]  stage_in;
  logic [15:0] cnt_reg [4];

  // Each stage counts the ticks of the one below
  assign stage_in = {tick[2:0], ce};

  for (genvar i = 0; i < 4; i++) begin : g_stage
    assign tick[i] = stage_in[i] && (cnt_reg[i] == DIVV[i*16 +: 16] - 16'h0001);
    // Stage divider
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        cnt_reg[i] <= 16'h0000;
      end else if (stage_in[i]) begin
        cnt_reg[i] <= tick[i] ? 16'h0000 : cnt_reg[i] + 16'h0001;
      end
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  AST_TICK_PULSE: assert property (tick[0] |=> !tick[0])
    else $error("base tick longer than one cycle");
endmodule : qtw_tick_gen
`default_nettype wire

// *** qtw_timer.sv ***
// One 24-bit up/down timer channel
`timescale 1ns/1ps
`default_nettype none
`include "qtw_defines.svh"
module qtw_timer
  import qtw_pkg::*;
#(
  parameter int CW = `QTW_CNT_W
) (
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          arst_n,
  input  wire logic          ce,
  // Control
  input  wire logic          run,
  input  wire logic          down,
  input  wire logic [1:0]    tsel,
  input  wire logic [CW-1:0] init,
  input  wire logic          kick,
  input  wire logic [3:0]    tick,
  // State
  output logic      [CW-1:0] count,
  output logic               evt
);
  localparam logic [CW-1:0] MAXV = CW'(`QTW_CNT_MAX);
  logic run_d_reg;
  logic load;
  logic adv;
  logic hit;

  // Trigger on run rising, reload on kick
  assign load = ce && (kick || (run && !run_d_reg));
  assign adv  = ce && run && tick[tsel] && !load;
  assign hit  = down ? (count == CW'(1)) : (count == MAXV - CW'(1));

  // Run edge detector
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_d_reg <= 1'b0;
    end else if (ce) begin
      run_d_reg <= run;
    end
  end

  // Count register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= CW'(0);
    end else if (load) begin
      count <= init;
    end else if (adv && !down) begin
      count <= (count == MAXV) ? init : count + CW'(1);
    end else if (adv) begin
      count <= (count == CW'(0)) ? init : count - CW'(1);
    end
  end

  // Event flag, pulses for one cycle as the count steps onto its target
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      evt <= 1'b0;
    end else if (ce) begin
      evt <= adv && hit;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  AST_UP_INC: assert property (adv && !down && count != MAXV |=> count == $past(count) + CW'(1))
    else $error("up count did not increment");
  AST_UP_WRAP: assert property (adv && !down && count == MAXV |=> count == $past(init))
    else $error("up count did not wrap to initial value");
  AST_DN_DEC: assert property (adv && down && count != CW'(0) |=> count == $past(count) - CW'(1))
    else $error("down count did not decrement");
  AST_DN_RELOAD: assert property (adv && down && count == CW'(0) |=> count == $past(init))
    else $error("down count did not reload");
  AST_EVT_TARGET: assert property (evt |-> count == ($past(down) ? CW'(0) : MAXV))
    else $error("event without count at target");
  AST_LOAD: assert property (load |=> count == $past(init))
    else $error("trigger did not load initial value");
  AST_HOLD: assert property (!adv && !load |=> count == $past(count))
    else $error("count moved without a tick");
endmodule : qtw_timer
`default_nettype wire

// *** qtw_top.sv ***
// Quad timer watchdog with Avalon-MM register slave
// Operation
// - Four independent timers, each with a 24-bit count.
// - Count advances once per tick of the selected time base.
// - Each timer holds its own time base select of four rates.
// - Up or down counting, both starting from the programmed initial value.
// - Up mode adds one per tick after the run trigger.
// - Up mode reloads the initial value after the all-ones count.
// - Up mode raises an interrupt when the count reaches all ones.
// - Down mode subtracts one per tick from the initial value.
// - Down mode at zero interrupts, reloads and keeps counting.
// - Watchdog-enabled down timer reaching zero resets the CPU.
//
// Local design decisions: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "qtw_defines.svh"
module qtw_top
  import qtw_pkg::*;
#(
  parameter int NTIM = `QTW_NTIM,
  parameter int DIV0 = `QTW_DIV0,
  parameter int DIV1 = `QTW_DIV1,
  parameter int DIV2 = `QTW_DIV2,
  parameter int DIV3 = `QTW_DIV3
) (
  // Clock, reset and enable
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  // Avalon-MM slave
  input  wire logic [6:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Interrupt and CPU reset
  output logic             irq,
  output logic             cpu_rst
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int CW = `QTW_CNT_W;
  localparam int SW = `QTW_STAT_W;

  qtw_bus_e           bus_state_reg;
  logic               req;
  logic               acc_wr;
  logic [3:0]         tick;
  logic [4:0]         ctrl_reg [NTIM];
  logic [CW-1:0]      init_reg [NTIM];
  logic [CW-1:0]      count    [NTIM];
  logic [NTIM-1:0]    kick;
  logic [NTIM-1:0]    evt;
  logic [NTIM-1:0]    wd_evt;
  logic [SW-1:0]      status_reg;
  logic [SW-1:0]      status_next;
  logic [SW-1:0]      mask_reg;
  logic [SW-1:0]      set_v;
  logic [4:0]         wd_cnt_reg;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Byte-lane merge of write data into an old value
  function automatic logic [31:0] bmerge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction : bmerge

  // Match a per-timer register
  function automatic logic treg(input logic [6:0] a, input int t, input logic [3:0] ofs);
    return (a[6] == 1'b0) && (a[5:4] == 2'(t)) && (a[3:0] == ofs);
  endfunction : treg

  // Read data for an address; unmapped reads as zero
  function automatic logic [31:0] rd_word(input logic [6:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int t = 0; t < NTIM; t++) begin
      if (treg(a, t, `QTW_OFS_CTRL)) begin
        r = 32'(ctrl_reg[t]);
      end
      if (treg(a, t, `QTW_OFS_INIT)) begin
        r = 32'(init_reg[t]);
      end
      if (treg(a, t, `QTW_OFS_COUNT)) begin
        r = 32'(count[t]);
      end
    end
    if (a == `QTW_OFS_STATUS) begin
      r = 32'(status_reg);
    end
    if (a == `QTW_OFS_MASK) begin
      r = 32'(mask_reg);
    end
    return r;
  endfunction : rd_word

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  // One wait cycle, then the access completes
  assign req             = avs_read || avs_write;
  assign avs_waitrequest = req && !(bus_state_reg == QTW_BUS_ACK && ce);
  assign acc_wr          = avs_write && ce && (bus_state_reg == QTW_BUS_ACK);

  // Bus state machine
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_state_reg <= QTW_BUS_IDLE;
    end else if (ce) begin
      case (bus_state_reg)
        QTW_BUS_IDLE: begin
          if (req) begin
            bus_state_reg <= QTW_BUS_ACK;
          end
        end
        QTW_BUS_ACK: begin
          bus_state_reg <= QTW_BUS_IDLE;
        end
        default: begin
          bus_state_reg <= QTW_BUS_IDLE;
        end
      endcase
    end
  end

  // Read data captured in the wait cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (ce && avs_read && bus_state_reg == QTW_BUS_IDLE) begin
      avs_readdata <= rd_word(avs_address);
    end
  end

  // ----------------------------------------------------------------
  // Per-timer control registers
  // ----------------------------------------------------------------
  // Control and initial value writes
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int t = 0; t < NTIM; t++) begin
        ctrl_reg[t] <= `QTW_CTRL_RST;
        init_reg[t] <= `QTW_INIT_RST;
      end
    end else if (acc_wr) begin
      for (int t = 0; t < NTIM; t++) begin
        if (treg(avs_address, t, `QTW_OFS_CTRL)) begin
          ctrl_reg[t] <= 5'(bmerge(32'(ctrl_reg[t]), avs_writedata, avs_byteenable));
        end
        if (treg(avs_address, t, `QTW_OFS_INIT)) begin
          init_reg[t] <= CW'(bmerge(32'(init_reg[t]), avs_writedata, avs_byteenable));
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Time base and timers
  // ----------------------------------------------------------------
  qtw_tick_gen #(
    .D0 (DIV0),
    .D1 (DIV1),
    .D2 (DIV2),
    .D3 (DIV3)
  ) u_tick (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .ce      (ce),
    .tick    (tick)
  );

  for (genvar i = 0; i < NTIM; i++) begin : g_tim
    // Any write to the kick register restores the initial value
    assign kick[i]   = acc_wr && treg(avs_address, i, `QTW_OFS_KICK);
    assign wd_evt[i] = evt[i] && ctrl_reg[i][`QTW_CTRL_DOWN] && ctrl_reg[i][`QTW_CTRL_WDEN];

    qtw_timer #(
      .CW (CW)
    ) u_tim (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .ce      (ce),
      .run     (ctrl_reg[i][`QTW_CTRL_RUN]),
      .down    (ctrl_reg[i][`QTW_CTRL_DOWN]),
      .tsel    (ctrl_reg[i][`QTW_CTRL_TSEL +: 2]),
      .init    (init_reg[i]),
      .kick    (kick[i]),
      .tick    (tick),
      .count   (count[i]),
      .evt     (evt[i])
    );
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  // Events set, write one clears; a set in the clearing cycle wins
  assign set_v = ce ? {wd_evt, evt} : '0;

  always_comb begin
    status_next = status_reg;
    if (acc_wr && avs_address == `QTW_OFS_STATUS && avs_byteenable[0]) begin
      status_next = status_reg & ~avs_writedata[SW-1:0];
    end
    status_next = status_next | set_v;
  end

  // Status register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_reg <= `QTW_STAT_RST;
    end else begin
      status_reg <= status_next;
    end
  end

  // Mask register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_reg <= `QTW_STAT_RST;
    end else if (acc_wr && avs_address == `QTW_OFS_MASK) begin
      mask_reg <= SW'(bmerge(32'(mask_reg), avs_writedata, avs_byteenable));
    end
  end

  assign irq = |(status_reg & mask_reg);

  // ----------------------------------------------------------------
  // Watchdog CPU reset
  // ----------------------------------------------------------------
  // Reset pulse stretched to a fixed width
  // A new expiry restarts the stretch, so overlapping expiries merge into one pulse
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_cnt_reg <= 5'h00;
    end else if (ce && |wd_evt) begin
      wd_cnt_reg <= 5'(`QTW_WD_RST_CYC);
    end else if (ce && wd_cnt_reg != 5'h00) begin
      wd_cnt_reg <= wd_cnt_reg - 5'h01;
    end
  end

  // Registered reset output
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_rst <= 1'b0;
    end else if (ce) begin
      cpu_rst <= (|wd_evt) || (wd_cnt_reg > 5'h01);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence s_access;
    req && bus_state_reg == QTW_BUS_IDLE && ce ##1 ce;
  endsequence
  sequence s_wd_fire;
    (|wd_evt) && ce ##1 ce;
  endsequence
  sequence s_clear;
    acc_wr && avs_address == `QTW_OFS_STATUS && avs_byteenable[0] && set_v == '0;
  endsequence
  property p_clear;
    s_clear |=> (status_reg & $past(avs_writedata[SW-1:0])) == '0;
  endproperty

  AST_BUS_ONE_WAIT: assert property (s_access |-> !avs_waitrequest)
    else $error("access not completed after one wait cycle");
  AST_WD_RST: assert property (s_wd_fire |=> cpu_rst)
    else $error("watchdog expiry did not reset the CPU");
  AST_SET_WINS: assert property (set_v != '0 |=> (status_reg & $past(set_v)) == $past(set_v))
    else $error("status event lost");
  AST_IRQ_FOLLOWS: assert property ((set_v & mask_reg) != '0 && !(acc_wr && avs_address == `QTW_OFS_MASK) |=> irq)
    else $error("unmasked event did not raise the interrupt");
  AST_NO_RST_UP: assert property ($rose(cpu_rst) |-> $past(|wd_evt))
    else $error("CPU reset without watchdog expiry");
  AST_WD_LOAD: assert property (ce && |wd_evt |=> wd_cnt_reg == 5'(`QTW_WD_RST_CYC))
    else $error("watchdog stretch counter not loaded");
  AST_RST_END: assert property ($fell(cpu_rst) |-> wd_cnt_reg == 5'h00)
    else $error("CPU reset ended before the stretch ran out");
  AST_STAT_CLR: assert property (p_clear)
    else $error("status bits not cleared by a write of one");
  AST_STAT_HOLD: assert property (!ce |=> status_reg == $past(status_reg))
    else $error("status changed while the clock enable was low");
endmodule : qtw_top
`default_nettype wire

// *** qtw_cpu_model.sv ***
// Embedded CPU model that watches the interrupt and reset lines of the timer block
`timescale 1ns/1ps
`default_nettype none
module qtw_cpu_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // Lines from the timer block
  input  wire logic        irq,
  input  wire logic        cpu_rst,
  // Observations for the bench
  output logic      [15:0] irq_rises,
  output logic      [31:0] irq_prev,
  output logic      [31:0] irq_last,
  output logic      [15:0] rst_rises,
  output logic      [15:0] rst_width
);
  logic [31:0] cyc_reg;
  logic        irq_d_reg;
  logic        rst_d_reg;
  logic [15:0] len_reg;

  // Stamp each interrupt rise with the cycle number, so periods come out exact
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cyc_reg   <= 32'h0;
      irq_d_reg <= 1'b0;
      irq_rises <= 16'h0;
      irq_prev  <= 32'h0;
      irq_last  <= 32'h0;
    end else begin
      cyc_reg   <= cyc_reg + 32'h1;
      irq_d_reg <= irq;
      if (irq && !irq_d_reg) begin
        irq_rises <= irq_rises + 16'h1;
        irq_prev  <= irq_last;
        irq_last  <= cyc_reg;
      end
    end
  end

  // Count reset pulses and keep the length of the latest one
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_d_reg <= 1'b0;
      len_reg   <= 16'h0;
      rst_rises <= 16'h0;
      rst_width <= 16'h0;
    end else begin
      rst_d_reg <= cpu_rst;
      len_reg   <= cpu_rst ? len_reg + 16'h1 : 16'h0;
      if (cpu_rst && !rst_d_reg) rst_rises <= rst_rises + 16'h1;
      if (!cpu_rst && rst_d_reg) rst_width <= len_reg;
    end
  end
endmodule : qtw_cpu_model
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the quad timer watchdog block
`timescale 1ns/1ps
`default_nettype none
`include "qtw_defines.svh"
module testbench;
  logic        sys_clk;
  logic        arst_n;
  logic        ce;
  logic [6:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        cpu_rst;
  logic [15:0] irq_rises;
  logic [31:0] irq_prev;
  logic [31:0] irq_last;
  logic [15:0] rst_rises;
  logic [15:0] rst_width;
  int          err_total;
  int          tests_run;

  // Short divider chain: ticks every 2, 4, 8 and 16 cycles
  qtw_top #(.DIV0(2), .DIV1(2), .DIV2(2), .DIV3(2)) dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .cpu_rst(cpu_rst));

  // Far side: the CPU that takes interrupts and resets
  qtw_cpu_model cpu (
    .sys_clk(sys_clk), .arst_n(arst_n), .irq(irq), .cpu_rst(cpu_rst),
    .irq_rises(irq_rises), .irq_prev(irq_prev), .irq_last(irq_last),
    .rst_rises(rst_rises), .rst_width(rst_width));

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One Avalon-MM access, held until waitrequest is sampled low
  task automatic acc(input logic wr, input logic [6:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= wd;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    chk("bus answer", {31'h0, n < 50}, 32'h1);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge sys_clk);
  endtask : acc

  // Wait for the next interrupt rise seen by the CPU model
  task automatic wait_irq();
    logic [15:0] r;
    int          n;
    r = irq_rises;
    n = 0;
    while (irq_rises === r && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    chk("irq arrives", {31'h0, n < 2000}, 32'h1);
  endtask : wait_irq

  // Run one timer, measure the interrupt period, then stop it and check hold
  task automatic run_case(input int t, input logic dn, input logic [23:0] iv,
                          input logic [1:0] ts, input logic [31:0] per);
    logic [31:0] v;
    logic [31:0] c;
    logic [6:0]  b;
    b = 7'(t * 16);
    acc(1'b1, b + 7'h04, {8'h00, iv}, v);
    acc(1'b1, 7'h44, 32'h1 << t, v);
    acc(1'b1, b, {27'h0, 1'b0, ts, dn, 1'b1}, v);
    wait_irq();
    acc(1'b1, 7'h40, 32'hFF, v);
    wait_irq();
    chk("irq period", irq_last - irq_prev, per);
    acc(1'b0, 7'h40, 32'h0, v);
    chk("status", v, 32'h1 << t);
    acc(1'b1, b, 32'h0, v);
    acc(1'b0, b + 7'h08, 32'h0, c);
    repeat (40) @(posedge sys_clk);
    acc(1'b0, b + 7'h08, 32'h0, v);
    chk("count holds", v, c);
    acc(1'b1, 7'h40, 32'hFF, v);
    chk("irq cleared", {31'h0, irq}, 32'h0);
  endtask : run_case

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] v;
    logic [31:0] c;
    int          n;
    sys_clk = 1'b0;
    arst_n = 1'b0;
    ce = 1'b1;
    avs_address = 7'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    err_total = 0;
    tests_run = 0;
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    // Reset values, unmapped places included
    for (int a = 0; a < 'h58; a += 4) begin
      if (a % 16 != 12 || a >= 64) begin
        acc(1'b0, 7'(a), 32'h0, v);
        chk("reset reg", v, 32'h0);
      end
    end
    chk("irq reset", {31'h0, irq}, 32'h0);
    chk("cpu_rst reset", {31'h0, cpu_rst}, 32'h0);
    // Count is read only; init and control keep only their width
    acc(1'b1, 7'h08, 32'h123, v);
    acc(1'b0, 7'h08, 32'h0, v);
    chk("count ro", v, 32'h0);
    acc(1'b1, 7'h34, 32'hFFABCDEF, v);
    acc(1'b0, 7'h34, 32'h0, v);
    chk("init width", v, 32'h00ABCDEF);
    // A write with one byte lane enabled changes only that lane
    avs_byteenable <= 4'h2;
    acc(1'b1, 7'h34, 32'h11223344, v);
    avs_byteenable <= 4'hF;
    acc(1'b0, 7'h34, 32'h0, v);
    chk("init lanes", v, 32'h00AB33EF);
    acc(1'b1, 7'h30, 32'hFFFFFFFE, v);
    acc(1'b0, 7'h30, 32'h0, v);
    chk("ctrl width", v, 32'h1E);
    acc(1'b1, 7'h30, 32'h0, v);
    // Down counting from 5 on every time base: period is six ticks
    for (int t = 0; t < 4; t++) begin
      run_case(t, 1'b1, 24'h5, 2'(t), 32'(12 << t));
    end
    // Up counting near the top: period is three ticks of 4 cycles
    run_case(1, 1'b0, 24'hFFFFFD, 2'h1, 32'h0C);
    // Clock enable low freezes a running timer: at most three enabled edges pass
    acc(1'b1, 7'h04, 32'h100, v);
    acc(1'b1, 7'h00, 32'h3, v);
    acc(1'b0, 7'h08, 32'h0, c);
    ce <= 1'b0;
    repeat (20) @(posedge sys_clk);
    ce <= 1'b1;
    acc(1'b0, 7'h08, 32'h0, v);
    chk("ce freeze", {31'h0, (c - v) <= 32'h2}, 32'h1);
    acc(1'b1, 7'h00, 32'h0, v);
    // Watchdog kept alive by kicks, then left to expire
    acc(1'b1, 7'h44, 32'h0, v);
    acc(1'b1, 7'h24, 32'h5, v);
    acc(1'b1, 7'h20, 32'h17, v);
    repeat (12) begin
      acc(1'b1, 7'h2C, 32'h0, v);
      repeat (6) @(posedge sys_clk);
    end
    chk("no cpu reset", {16'h0, rst_rises}, 32'h0);
    n = 0;
    while (rst_rises === 16'h0 && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    acc(1'b1, 7'h20, 32'h0, v);
    chk("cpu reset", {16'h0, rst_rises}, 32'h1);
    n = 0;
    while (rst_width === 16'h0 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    chk("reset width", {16'h0, rst_width}, `QTW_WD_RST_CYC);
    acc(1'b0, 7'h40, 32'h0, v);
    chk("wd status", v, 32'h44);
    chk("irq masked", {31'h0, irq}, 32'h0);
    acc(1'b1, 7'h44, 32'h40, v);
    chk("irq unmasked", {31'h0, irq}, 32'h1);
    acc(1'b1, 7'h40, 32'h44, v);
    acc(1'b0, 7'h40, 32'h0, v);
    chk("status clear", v, 32'h0);
    chk("irq low", {31'h0, irq}, 32'h0);
    stop_test();
  end

  // Watchdog against a hang
  initial begin
    repeat (30000) @(posedge sys_clk);
    err_total++;
    stop_test();
  end
endmodule : testbench
`default_nettype wire
